// ===== adcsq_sequencer.sv
// conversion sequencer control with avalon-mm register slave
//
// Operation
// - mode 01 then start trigger converts the selected channel exactly once.
// - start trigger clears itself once a conversion begins, in both modes.
// - busy flag sets at conversion start, clears on single-mode completion or forced stop.
// - completion stores result, sets done flag, pulses the done interrupt.
// - reading the high result register clears the done flag.
// - mode 11 then start trigger converts the selected channel repeatedly.
// - in repeat mode the next conversion starts right after each completion.
// - completion between low and high result reads keeps old result, no interrupt.
// - writing mode 00 aborts a conversion at once, storing no result.
// - mode 00 clears done, busy and both result registers.
// - new start before high read clears done; old result stays until completion.
// - low-power entry stops conversion and clears trigger, mode, enable, flags, results.
// - after low power nothing restarts until software configures and starts again.
// - low-power entry during conversion disconnects the analog reference.
// - each result is a 10-bit unsigned code split over low and high.
// - time codes 000..101 give 39..1248 clocks; 110 and 111 are reserved.
// - low holds bits 7..0, high holds bits 9..8, upper bits read zero.
`include "adcsq_defines.svh"
module adcsq_sequencer #(
    parameter int RES_W = `ADCSQ_RES_W
) (
    input  wire logic                        core_clk,
    input  wire logic                        srst,
    input  wire logic                        clk_en,
    input  wire adcsq_pkg::adcsq_avm_req_type avs_req,
    output adcsq_pkg::adcsq_avm_rsp_type      avs_rsp,
    input  wire logic [RES_W-1:0]            conv_data,
    input  wire logic                        low_power_enter,
    output adcsq_pkg::adcsq_link_type         link,
    output logic                             conversion_done_interrupt
);
    import adcsq_pkg::*;

    adcsq_state_type  state_q;
    adcsq_state_type  state_d;
    logic             ack_q;
    logic [31:0]      readdata_q;
    logic             start_trigger_q;
    logic [1:0]       operating_mode_select_q;
    logic             analog_input_enable_q;
    logic [3:0]       channel_select_q;
    logic [2:0]       time_sel_q;
    logic             conversion_done_flag_q;
    logic [RES_W-1:0] result_q;
    logic             low_read_pend_q;
    logic             irq_q;
    logic             ref_disc_q;
    logic             expire;

    wire              bus_req;
    wire              bus_acc;
    wire              wr_ctrl_one;
    wire              wr_ctrl_two;
    wire              rd_res_low;
    wire              rd_res_high;
    wire [31:0]       wdata;
    wire              mode_stop;
    wire              abort;
    wire              mode_run;
    wire              is_repeat;
    wire              conversion_busy_flag;
    wire              start_go;
    wire              done_evt;
    wire              keep_old;
    wire              low_rd_open;
    wire              store;
    wire              timer_load;
    wire [31:0]       rd_ctrl_one_val;
    wire [31:0]       rd_ctrl_two_val;
    wire [31:0]       rd_low_val;
    wire [31:0]       rd_high_val;
    wire [31:0]       rd_mux;

    // bus decode: one wait cycle on every access, so read data are always registered
    assign bus_req     = avs_req.read || avs_req.write;
    // a low clock enable holds the answer off, so no write is lost while frozen
    assign bus_acc     = bus_req && ack_q && clk_en;
    assign wdata       = avs_req.writedata;
    assign wr_ctrl_one = bus_acc && avs_req.write && (avs_req.address == `ADCSQ_ADDR_CTRL_ONE);
    assign wr_ctrl_two = bus_acc && avs_req.write && (avs_req.address == `ADCSQ_ADDR_CTRL_TWO);
    assign rd_res_low  = bus_acc && avs_req.read && (avs_req.address == `ADCSQ_ADDR_RES_LOW);
    assign rd_res_high = bus_acc && avs_req.read && (avs_req.address == `ADCSQ_ADDR_RES_HIGH);

    assign avs_rsp.waitrequest = bus_req && !bus_acc;
    assign avs_rsp.readdata    = readdata_q;

    // sequencing terms
    assign mode_stop = wr_ctrl_one && (wdata[`ADCSQ_MODE_MSB:`ADCSQ_MODE_LSB] == `ADCSQ_MODE_OFF);
    assign abort     = mode_stop || low_power_enter;
    assign is_repeat = (operating_mode_select_q == `ADCSQ_MODE_REPEAT);
    assign mode_run  = (operating_mode_select_q == `ADCSQ_MODE_SINGLE) || is_repeat;
    assign conversion_busy_flag = (state_q == ST_CONVERT);
    assign start_go  = (state_q == ST_IDLE) && start_trigger_q && mode_run && !abort;
    assign done_evt  = (state_q == ST_CONVERT) && expire && !abort;
    // a completion landing between the two result reads must not tear the pair
    assign low_rd_open = avs_req.read && (avs_req.address == `ADCSQ_ADDR_RES_LOW);
    assign keep_old  = done_evt && (low_read_pend_q || low_rd_open);
    assign store     = done_evt && !(low_read_pend_q || low_rd_open);
    assign timer_load = start_go || (done_evt && is_repeat);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_go) begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (abort) begin
                    state_d = ST_IDLE;
                end else if (done_evt && !is_repeat) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // read back
    assign rd_ctrl_one_val = {24'h000000, start_trigger_q, operating_mode_select_q,
                              analog_input_enable_q, channel_select_q};
    assign rd_ctrl_two_val = {24'h000000, conversion_done_flag_q, conversion_busy_flag, 3'h0, time_sel_q};
    assign rd_low_val      = {24'h000000, result_q[`ADCSQ_RES_LOW_MSB:0]};
    assign rd_high_val     = {30'h00000000, result_q[RES_W-1:`ADCSQ_RES_HIGH_LSB]};
    assign rd_mux = (avs_req.address == `ADCSQ_ADDR_CTRL_ONE) ? rd_ctrl_one_val :
                    (avs_req.address == `ADCSQ_ADDR_CTRL_TWO) ? rd_ctrl_two_val :
                    (avs_req.address == `ADCSQ_ADDR_RES_LOW)  ? rd_low_val :
                    (avs_req.address == `ADCSQ_ADDR_RES_HIGH) ? rd_high_val : 32'h00000000;

    assign link.conv_active    = conversion_busy_flag;
    assign link.channel        = channel_select_q;
    assign link.input_enable   = analog_input_enable_q;
    assign link.ref_disconnect = ref_disc_q;
    assign conversion_done_interrupt = irq_q;

    adcsq_conv_timer #(
        .CNT_W (`ADCSQ_CNT_W),
        .BASE  (`ADCSQ_BASE_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .load     (timer_load),
        .abort    (abort),
        .time_sel (time_sel_q),
        .expire   (expire)
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_q      <= 1'b0;
            readdata_q <= 32'h00000000;
        end else if (clk_en) begin
            ack_q <= bus_req && !ack_q;
            if (bus_req && !ack_q && avs_req.read) begin
                readdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // control register one; low power wipes all but the channel so nothing resumes afterwards
    always_ff @(posedge core_clk) begin
        if (srst) begin
            start_trigger_q         <= 1'b0;
            operating_mode_select_q <= `ADCSQ_MODE_OFF;
            analog_input_enable_q   <= 1'b0;
            channel_select_q        <= `ADCSQ_CH_RESET;
        end else if (clk_en) begin
            if (low_power_enter) begin
                start_trigger_q         <= 1'b0;
                operating_mode_select_q <= `ADCSQ_MODE_OFF;
                analog_input_enable_q   <= 1'b0;
            end else if (wr_ctrl_one) begin
                start_trigger_q         <= wdata[`ADCSQ_START_BIT];
                operating_mode_select_q <= wdata[`ADCSQ_MODE_MSB:`ADCSQ_MODE_LSB];
                analog_input_enable_q   <= wdata[`ADCSQ_AIEN_BIT];
                channel_select_q        <= wdata[`ADCSQ_CH_MSB:`ADCSQ_CH_LSB];
            end else if (state_q == ST_IDLE) begin
                // a trigger with mode off is simply dropped
                start_trigger_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            time_sel_q <= `ADCSQ_TIME_RESET;
        end else if (clk_en && wr_ctrl_two) begin
            time_sel_q <= wdata[`ADCSQ_TIME_MSB:`ADCSQ_TIME_LSB];
        end
    end

    // done flag: a completion wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            conversion_done_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (abort) begin
                conversion_done_flag_q <= 1'b0;
            end else if (store) begin
                conversion_done_flag_q <= 1'b1;
            end else if (rd_res_high || start_go) begin
                conversion_done_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            result_q        <= `ADCSQ_RES_RESET;
            low_read_pend_q <= 1'b0;
            irq_q           <= 1'b0;
        end else if (clk_en) begin
            irq_q <= store;
            if (abort) begin
                result_q <= `ADCSQ_RES_RESET;
            end else if (store) begin
                result_q <= conv_data;
            end
            if (abort || rd_res_high) begin
                low_read_pend_q <= 1'b0;
            end else if (rd_res_low) begin
                low_read_pend_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ref_disc_q <= 1'b0;
        end else if (clk_en) begin
            if (low_power_enter && conversion_busy_flag) begin
                ref_disc_q <= 1'b1;
            end else if (start_go) begin
                ref_disc_q <= 1'b0;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_start_clears_trig: assert property (start_go && clk_en && !wr_ctrl_one |=> !start_trigger_q)
        else $error("start trigger not cleared after start");
    a_busy_on_start: assert property (start_go && clk_en |=> conversion_busy_flag)
        else $error("busy not set at start");
    a_abort_stops_busy: assert property (abort && clk_en |=> !conversion_busy_flag)
        else $error("busy still set after abort");
    a_store_result_done: assert property (store && clk_en |=> conversion_done_flag_q
        && result_q == $past(conv_data))
        else $error("completion did not store result and set done");
    a_irq_with_done: assert property (irq_q |-> conversion_done_flag_q)
        else $error("interrupt without done flag");
    a_high_read_clears: assert property (rd_res_high && clk_en && !store |=> !conversion_done_flag_q)
        else $error("high read did not clear done");
    a_repeat_restarts: assert property (done_evt && is_repeat && clk_en |=> conversion_busy_flag)
        else $error("repeat mode did not restart");
    a_pair_hold_old: assert property (keep_old && clk_en |=> $stable(result_q) && !irq_q)
        else $error("result overwritten between low and high reads");
    a_stop_clears_all: assert property (mode_stop && clk_en |=> !conversion_done_flag_q && result_q == '0)
        else $error("mode off did not clear flags and results");
    a_low_power_wipe: assert property (low_power_enter && clk_en |=> !start_trigger_q
        && operating_mode_select_q == `ADCSQ_MODE_OFF && !analog_input_enable_q && !conversion_busy_flag)
        else $error("low power entry did not clear control");
    a_ref_disconnect: assert property (low_power_enter && conversion_busy_flag && clk_en |=> ref_disc_q)
        else $error("reference not disconnected on low power");
    a_high_upper_zero: assert property (avs_req.address == `ADCSQ_ADDR_RES_HIGH |-> rd_mux[31:2] == '0)
        else $error("high result upper bits not zero");
    a_irq_one_cycle: assert property (irq_q && clk_en |=> !irq_q)
        else $error("done interrupt longer than one cycle");
    a_single_ends_idle: assert property (done_evt && !is_repeat && clk_en |=> !conversion_busy_flag)
        else $error("single conversion did not return to idle");
    a_start_clears_done: assert property (start_go && clk_en |=> !conversion_done_flag_q)
        else $error("new start did not clear done");
    a_abort_no_irq: assert property (abort && clk_en |=> !irq_q)
        else $error("aborted conversion raised the interrupt");
    a_idle_trigger_drop: assert property (start_trigger_q && !mode_run && !conversion_busy_flag && clk_en
        && !wr_ctrl_one |=> !start_trigger_q)
        else $error("trigger with mode off not dropped");
    a_no_self_start: assert property (!conversion_busy_flag && !start_trigger_q && clk_en |=> !conversion_busy_flag)
        else $error("conversion started without a trigger");
    a_result_only_store: assert property (!store && !abort && clk_en |=> $stable(result_q))
        else $error("result changed without a completion");
endmodule

// ===== adcsq_defines.svh
// register offsets, field positions, codes and timing counts of the conversion sequencer
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH

`define ADCSQ_ADDR_W          4
`define ADCSQ_ADDR_CTRL_ONE   4'h0
`define ADCSQ_ADDR_CTRL_TWO   4'h4
`define ADCSQ_ADDR_RES_LOW    4'h8
`define ADCSQ_ADDR_RES_HIGH   4'hC

`define ADCSQ_CH_LSB          0
`define ADCSQ_CH_MSB          3
`define ADCSQ_AIEN_BIT        4
`define ADCSQ_MODE_LSB        5
`define ADCSQ_MODE_MSB        6
`define ADCSQ_START_BIT       7
`define ADCSQ_TIME_LSB        0
`define ADCSQ_TIME_MSB        2
`define ADCSQ_BUSY_BIT        6
`define ADCSQ_DONE_BIT        7

`define ADCSQ_MODE_OFF        2'h0
`define ADCSQ_MODE_SINGLE     2'h1
`define ADCSQ_MODE_REPEAT     2'h3

`define ADCSQ_RES_W           10
`define ADCSQ_RES_LOW_MSB     7
`define ADCSQ_RES_HIGH_LSB    8
`define ADCSQ_RES_RESET       10'h000
`define ADCSQ_CH_RESET        4'h0
`define ADCSQ_TIME_RESET      3'h0

`define ADCSQ_CNT_W           11
`define ADCSQ_BASE_CYCLES     11'h027
`define ADCSQ_TIME_MAX_CODE   3'h5
`define ADCSQ_CNT_ONE         11'h001
`define ADCSQ_CNT_ZERO        11'h000

`endif

// ===== adcsq_pkg.sv
// types shared by the conversion sequencer files
package adcsq_pkg;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } adcsq_avm_req_type;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } adcsq_avm_rsp_type;

    typedef struct packed {
        logic        conv_active;
        logic [3:0]  channel;
        logic        input_enable;
        logic        ref_disconnect;
    } adcsq_link_type;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_CONVERT
    } adcsq_state_type;

endpackage

// ===== adcsq_conv_timer.sv
// conversion timer: counts the selected number of clock periods
`include "adcsq_defines.svh"
module adcsq_conv_timer #(
    parameter int                  CNT_W = `ADCSQ_CNT_W,
    parameter logic [CNT_W-1:0]    BASE  = `ADCSQ_BASE_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic              load,
    input  wire logic              abort,
    input  wire logic [2:0]        time_sel,
    output logic                   expire
);
    logic [CNT_W-1:0] cnt_q;
    logic             run_q;
    wire  [2:0]       sel_eff;
    wire  [CNT_W-1:0] load_val;

    // reserved codes fall back to the longest time, the safe side for accuracy
    assign sel_eff  = (time_sel > `ADCSQ_TIME_MAX_CODE) ? `ADCSQ_TIME_MAX_CODE : time_sel;
    assign load_val = CNT_W'(BASE << sel_eff);
    assign expire   = run_q && (cnt_q == `ADCSQ_CNT_ONE) && !abort;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_q <= `ADCSQ_CNT_ZERO;
            run_q <= 1'b0;
        end else if (clk_en) begin
            if (abort) begin
                run_q <= 1'b0;
            end else if (load) begin
                cnt_q <= load_val;
                run_q <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - `ADCSQ_CNT_ONE;
                run_q <= (cnt_q != `ADCSQ_CNT_ONE);
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_timer_load_value: assert property (load && !abort && clk_en |=> cnt_q == $past(load_val) && run_q)
        else $error("timer not loaded with selected count");
    a_timer_expire_end: assert property (expire && clk_en && !load |=> !run_q)
        else $error("timer still running after expiry");
endmodule

// ===== adcsq_conv_model.sv
// analog channel model feeding conversion codes to the sequencer
module adcsq_conv_model (
    input  wire logic                      core_clk,
    input  wire adcsq_pkg::adcsq_link_type link,
    output logic [9:0]                     conv_data
);
    timeunit 1ns;
    timeprecision 1ns;
    import adcsq_pkg::*;
    logic [9:0] code_q = 10'h155;
    assign conv_data = code_q;
    // a deselected input holds no level, so the code keeps toggling
    always_ff @(posedge core_clk) begin
        if (link.conv_active && link.input_enable) begin
            code_q <= {link.channel, 2'b10, ~link.channel};
        end else begin
            code_q <= ~code_q;
        end
    end
endmodule

// ===== adcsq_sequencer_tb_top.sv
// self-checking bench for the conversion sequencer
module adcsq_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import adcsq_pkg::*;
    logic              core_clk = 1'b0;
    logic              srst = 1'b1;
    logic              clk_en = 1'b1;
    logic              low_power_enter = 1'b0;
    logic [9:0]        conv_data;
    logic              irq;
    adcsq_avm_req_type req = '0;
    adcsq_avm_rsp_type rsp;
    adcsq_link_type    link;
    int                fail_count = 0;
    int                checks_done = 0;
    logic [31:0]       rd;
    int                n;

    always #20 core_clk = ~core_clk;

    adcsq_sequencer dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .avs_req(req), .avs_rsp(rsp),
        .conv_data(conv_data), .low_power_enter(low_power_enter), .link(link), .conversion_done_interrupt(irq));
    adcsq_conv_model model (.core_clk(core_clk), .link(link), .conv_data(conv_data));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [9:0] code(input logic [3:0] ch);
        return {ch, 2'b10, ~ch};
    endfunction

    // hold the request until waitrequest is seen low, then release
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        @(posedge core_clk);
        req <= '{read: !wr, write: wr, address: a, writedata: wd};
        do begin
            @(posedge core_clk);
            #1;
            w++;
        end while (rsp.waitrequest !== 1'b0 && w < 50);
        @(posedge core_clk);
        rd = rsp.readdata;
        req <= '0;
        if (w >= 50) begin
            chk("bus answer", 32'h1, 32'h0);
        end
    endtask

    task automatic rdreg(input logic [3:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic wait_irq(input int lim);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (irq !== 1'b1 && n <= lim);
    endtask

    task automatic t_reset();
        rdreg(4'h0, 32'h0, "ctrl one reset");
        rdreg(4'h4, 32'h0, "ctrl two reset");
        rdreg(4'h8, 32'h0, "low reset");
        rdreg(4'hC, 32'h0, "high reset");
        bus(1'b1, 4'h2, 32'hFF);
        rdreg(4'h2, 32'h0, "unmapped read");
        rdreg(4'h0, 32'h0, "unmapped write ignored");
    endtask

    task automatic t_single(input logic [2:0] sel, input logic [3:0] ch);
        logic [9:0] c;
        int         nexp;
        c = code(ch);
        nexp = (sel > 3'h5) ? 1248 : (39 << sel);
        bus(1'b1, 4'h0, {24'h0, 4'b0011, ch});
        bus(1'b1, 4'h4, {29'h0, sel});
        bus(1'b1, 4'h0, {24'h0, 4'b1011, ch});
        wait_irq(1260);
        chk("completion cycles", 32'(nexp + 1), 32'(n));
        chk("busy after done", 32'h0, {31'h0, link.conv_active});
        bus(1'b0, 4'h4, 32'h0);
        chk("flags at done", 32'h80, rd & 32'hFFFFFFF8);
        rdreg(4'h8, {24'h0, c[7:0]}, "result low");
        rdreg(4'hC, {30'h0, c[9:8]}, "result high");
        bus(1'b0, 4'h4, 32'h0);
        chk("done after high read", 32'h0, rd & 32'hC0);
        wait_irq(100);
        chk("single converts once", 32'h0, {31'h0, n <= 100});
    endtask

    // clock enable low for 20 edges must push completion out by 20 cycles
    task automatic t_freeze();
        bus(1'b1, 4'h0, 32'h32);
        bus(1'b1, 4'h4, 32'h0);
        bus(1'b1, 4'h0, 32'hB2);
        repeat (10) @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (19) @(posedge core_clk);
        #1;
        chk("busy while frozen", 32'h1, {31'h0, link.conv_active});
        @(posedge core_clk);
        clk_en <= 1'b1;
        wait_irq(100);
        chk("frozen completion", 32'd30, 32'(n));
        rdreg(4'h8, {22'h0, code(4'h2) & 10'h0FF}, "frozen result low");
        rdreg(4'hC, 32'h0, "frozen result high");
    endtask

    task automatic t_restart();
        logic [9:0] c;
        c = code(4'h5);
        bus(1'b1, 4'h0, 32'h33);
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b1, 4'h0, 32'hB3);
        wait_irq(100);
        // channel change only while idle
        bus(1'b1, 4'h0, 32'h35);
        bus(1'b1, 4'h0, 32'hB5);
        bus(1'b0, 4'h4, 32'h0);
        chk("start clears done", 32'h40, rd & 32'hC0);
        rdreg(4'h0, 32'h35, "start self clears");
        rdreg(4'hC, 32'h0, "old result kept");
        wait_irq(100);
        chk("restart completes", 32'h1, {31'h0, n <= 100});
        rdreg(4'h8, {24'h0, c[7:0]}, "new result low");
        rdreg(4'hC, {30'h0, c[9:8]}, "new result high");
    endtask

    task automatic t_repeat();
        bus(1'b1, 4'h0, 32'h77);
        bus(1'b1, 4'h4, 32'h0);
        bus(1'b1, 4'h0, 32'hF7);
        wait_irq(50);
        chk("first repeat result", 32'd40, 32'(n));
        wait_irq(50);
        chk("next starts at once", 32'd39, 32'(n));
        rdreg(4'h0, 32'h77, "repeat start cleared");
        // pair left open on purpose across a completion
        rdreg(4'h8, {22'h0, code(4'h7) & 10'h0FF}, "repeat low");
        wait_irq(45);
        chk("no irq while pair open", 32'h0, {31'h0, n <= 45});
        bus(1'b0, 4'h4, 32'h0);
        chk("flags while pair open", 32'hC0, rd & 32'hC0);
        rdreg(4'hC, {30'h0, 2'b01}, "kept high");
        wait_irq(45);
        chk("irq resumes", 32'h1, {31'h0, n <= 45});
        bus(1'b1, 4'h0, 32'h17);
        bus(1'b0, 4'h4, 32'h0);
        chk("flags after stop", 32'h0, rd & 32'hC0);
        rdreg(4'h8, 32'h0, "low after stop");
        rdreg(4'hC, 32'h0, "high after stop");
        wait_irq(60);
        chk("stop stores nothing", 32'h0, {31'h0, n <= 60});
    endtask

    task automatic t_lowpower();
        bus(1'b1, 4'h0, 32'h79);
        bus(1'b1, 4'h4, 32'h2);
        bus(1'b1, 4'h0, 32'hF9);
        wait_irq(200);
        repeat (20) @(posedge core_clk);
        low_power_enter <= 1'b1;
        @(posedge core_clk);
        low_power_enter <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("reference cut", 32'h1, {31'h0, link.ref_disconnect});
        chk("busy output", 32'h0, {31'h0, link.conv_active});
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl one cleared", 32'h0, rd & 32'hF0);
        bus(1'b0, 4'h4, 32'h0);
        chk("flags cleared", 32'h0, rd & 32'hC0);
        rdreg(4'h8, 32'h0, "low cleared");
        rdreg(4'hC, 32'h0, "high cleared");
        wait_irq(400);
        chk("no resume", 32'h0, {31'h0, n <= 400 || link.conv_active !== 1'b0});
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
        t_single(3'h0, 4'h3);
        t_single(3'h1, 4'h6);
        t_single(3'h6, 4'hC);
        t_freeze();
        t_restart();
        t_repeat();
        t_lowpower();
        end_of_test();
    end

    // whole sequence needs about 2900 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end
endmodule
